//--- pkg/scc_pkg.sv
package scc_pkg;

	// ************************************************************
	// Register addresses on the special function register port.
	// ************************************************************
	localparam logic [7:0] ADDR_CONFIG  = 8'hbc;
	localparam logic [7:0] ADDR_RES_LO  = 8'hbd;
	localparam logic [7:0] ADDR_RES_HI  = 8'hbe;
	localparam logic [7:0] ADDR_CONTROL = 8'he8;

	// ************************************************************
	// Values after reset.
	// ************************************************************
	localparam logic [7:0] CONFIG_RESET  = 8'hf9;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] RESULT_RESET  = 8'h00;

	// ************************************************************
	// Field positions of the configuration register.
	// ************************************************************
	localparam int CFG_DIV_MSB   = 7;
	localparam int CFG_DIV_LSB   = 3;
	localparam int CFG_LJST_BIT  = 2;
	localparam int CFG_8BIT_BIT  = 1;
	localparam int CFG_GAIN_BIT  = 0;

	// ************************************************************
	// Field positions of the control register.
	// ************************************************************
	localparam int CTL_EN_BIT    = 7;
	localparam int CTL_TRACK_BIT = 6;
	localparam int CTL_DONE_BIT  = 5;
	localparam int CTL_BUSY_BIT  = 4;
	localparam int CTL_SRC_MSB   = 2;
	localparam int CTL_SRC_LSB   = 0;

	// ************************************************************
	// Tracking delay in SAR clock cycles and result bit indices.
	// ************************************************************
	localparam logic [1:0] TRACK_DELAY_TICKS = 2'd3;
	localparam logic [3:0] RES_MSB_IDX       = 4'd9;
	localparam logic [3:0] LSB_IDX_10BIT     = 4'd0;
	localparam logic [3:0] LSB_IDX_8BIT      = 4'd2;

	// ************************************************************
	// Start-of-conversion sources.
	// ************************************************************
	typedef enum logic [2:0] {
		SRC_SOFTWARE = 3'b000,
		SRC_TIMER0   = 3'b001,
		SRC_TIMER2   = 3'b010,
		SRC_TIMER1   = 3'b011,
		SRC_EXT_PIN  = 3'b100,
		SRC_TIMER3   = 3'b101
	} scc_src_e;

	// ************************************************************
	// Sequencer states.
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_DELAY = 2'b01,
		ST_CONV  = 2'b10
	} scc_state_e;

endpackage

//--- pkg/scc_tick_if.sv
`timescale 1ns/1ns
`default_nettype none

interface scc_tick_if;
	logic [4:0] div;
	logic       run;
	logic       tick;

	// Control side sets the ratio and receives SAR clock ticks.
	modport ctrl (output div, output run, input tick);
	// Divider side produces the ticks.
	modport gen (input div, input run, output tick);
endinterface

`default_nettype wire

//--- src/scc_sar_divider.sv
`timescale 1ns/1ns
`default_nettype none

module scc_sar_divider (
	// Clock and reset.
	input  wire logic clk_sys_i,
	input  wire logic rst_b_i,
	// Tick channel.
	scc_tick_if.gen   tk
);

	logic [4:0] cnt;

	// One tick every div+1 system clocks; held at zero while idle so
	// the first SAR period after a start is always a full one.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 5'h00;
		end else if (!tk.run || cnt == tk.div) begin
			cnt <= 5'h00;
		end else begin
			cnt <= cnt + 5'h01;
		end
	end

	assign tk.tick = tk.run && (cnt == tk.div);

endmodule

`default_nettype wire

//--- src/scc_conv_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Conversion control for the 10-bit SAR converter.
// ************************************************************

module scc_conv_ctrl (
	// Clock and reset.
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	// Special function register port.
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_wr_i,
	input  wire logic       sfr_rd_i,
	output logic      [7:0] sfr_rdata_o,
	// Trigger sources.
	input  wire logic       t0_ovf_i,
	input  wire logic       t1_ovf_i,
	input  wire logic       t2_lo_ovf_i,
	input  wire logic       t2_hi_ovf_i,
	input  wire logic       t2_split8_i,
	input  wire logic       t3_lo_ovf_i,
	input  wire logic       t3_hi_ovf_i,
	input  wire logic       t3_split8_i,
	input  wire logic       external_convert_start_i,
	// Analog front end.
	input  wire logic       cmp_i,
	output logic      [9:0] sar_trial_o,
	output logic            track_o,
	output logic            analog_enable_o,
	output logic            input_gain_select_o,
	// Completion flag towards the interrupt controller.
	output logic            conversion_done_flag_o
);

	// ************************************************************
	// Reset release and register storage.
	// ************************************************************
	logic                  rst_meta_b;
	logic                  rst_b;
	logic [7:0]            converter_config_reg;
	logic [7:0]            result_high_byte;
	logic [7:0]            result_low_byte;
	logic                  converter_enable_bit;
	logic                  delayed_track_select;
	logic                  conversion_done_flag;
	logic [2:0]            start_source_select;
	scc_pkg::scc_state_e   state;
	logic [1:0]            delay_cnt;
	logic [3:0]            bit_idx;
	logic [9:0]            trial;
	logic [2:0]            ext_sync;
	logic                  ext_level;
	logic                  ext_rise;
	logic                  start_evt;
	logic                  sw_start;
	logic                  finish;
	logic                  busy;
	logic                  eight_bit_mode_sel;
	logic                  left_justify_select;
	logic [3:0]            last_idx;
	logic [9:0]            final_code;
	logic                  wr_cfg;
	logic                  wr_ctl;

	scc_tick_if tk ();

	// Reset is asserted at once and released through two flip-flops.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_b <= 1'b0;
			rst_b      <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_b      <= rst_meta_b;
		end
	end

	assign wr_cfg              = sfr_wr_i && (sfr_addr_i == scc_pkg::ADDR_CONFIG);
	assign wr_ctl              = sfr_wr_i && (sfr_addr_i == scc_pkg::ADDR_CONTROL);
	assign eight_bit_mode_sel  = converter_config_reg[scc_pkg::CFG_8BIT_BIT];
	assign left_justify_select = converter_config_reg[scc_pkg::CFG_LJST_BIT];
	assign busy                = (state != scc_pkg::ST_IDLE);

	// ************************************************************
	// SAR clock divider.
	// ************************************************************
	assign tk.div = converter_config_reg[scc_pkg::CFG_DIV_MSB:scc_pkg::CFG_DIV_LSB];
	assign tk.run = busy;

	scc_sar_divider u_div (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b),
		.tk        (tk)
	);

	// ************************************************************
	// External start pin: three stages, level accepted on agreement.
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge rst_b) begin
		if (!rst_b) begin
			ext_sync  <= 3'b000;
			ext_level <= 1'b0;
		end else begin
			ext_sync <= {ext_sync[1:0], external_convert_start_i};
			if (ext_sync[1] == ext_sync[2]) begin
				ext_level <= ext_sync[2];
			end
		end
	end

	// A glitch shorter than two clocks never reaches the edge detector.
	assign ext_rise = (ext_sync[1] == ext_sync[2]) && ext_sync[2] && !ext_level;

	// ************************************************************
	// Trigger selection.
	// ************************************************************
	assign sw_start = wr_ctl && sfr_wdata_i[scc_pkg::CTL_BUSY_BIT];

	// Timers 2 and 3 pick their byte overflow from their own width mode.
	always_comb begin
		unique case (start_source_select)
			scc_pkg::SRC_SOFTWARE: start_evt = sw_start;
			scc_pkg::SRC_TIMER0:   start_evt = t0_ovf_i;
			scc_pkg::SRC_TIMER2:   start_evt = t2_split8_i ? t2_lo_ovf_i : t2_hi_ovf_i;
			scc_pkg::SRC_TIMER1:   start_evt = t1_ovf_i;
			scc_pkg::SRC_EXT_PIN:  start_evt = ext_rise;
			scc_pkg::SRC_TIMER3:   start_evt = t3_split8_i ? t3_lo_ovf_i : t3_hi_ovf_i;
			default:               start_evt = 1'b0;
		endcase
	end

	// ************************************************************
	// Conversion sequencer.
	// ************************************************************
	assign last_idx   = eight_bit_mode_sel ? scc_pkg::LSB_IDX_8BIT : scc_pkg::LSB_IDX_10BIT;
	// Enable gates completion too, so a disable that lands on the last tick aborts cleanly.
	assign finish     = converter_enable_bit && (state == scc_pkg::ST_CONV) && tk.tick
	                    && (bit_idx == last_idx);
	assign final_code = cmp_i ? trial : (trial & ~(10'h001 << bit_idx));

	// Triggers arriving while busy are dropped; a new start needs idle.
	always_ff @(posedge clk_sys_i or negedge rst_b) begin
		if (!rst_b) begin
			state     <= scc_pkg::ST_IDLE;
			delay_cnt <= 2'd0;
			bit_idx   <= 4'd0;
			trial     <= 10'h000;
		end else if (!converter_enable_bit) begin
			state <= scc_pkg::ST_IDLE;
			trial <= 10'h000;
		end else begin
			unique case (state)
				scc_pkg::ST_IDLE: begin
					if (start_evt) begin
						delay_cnt <= 2'd0;
						bit_idx   <= scc_pkg::RES_MSB_IDX;
						trial     <= 10'h200;
						state     <= delayed_track_select ? scc_pkg::ST_DELAY
						                                  : scc_pkg::ST_CONV;
					end
				end
				scc_pkg::ST_DELAY: begin
					if (tk.tick) begin
						delay_cnt <= delay_cnt + 2'd1;
						if (delay_cnt == scc_pkg::TRACK_DELAY_TICKS - 2'd1) begin
							state <= scc_pkg::ST_CONV;
						end
					end
				end
				scc_pkg::ST_CONV: begin
					if (tk.tick) begin
						trial <= final_code;
						if (bit_idx == last_idx) begin
							state <= scc_pkg::ST_IDLE;
						end else begin
							bit_idx <= bit_idx - 4'd1;
							trial   <= final_code | (10'h001 << (bit_idx - 4'd1));
						end
					end
				end
				default: state <= scc_pkg::ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Tracking and analog controls.
	// ************************************************************
	always_comb begin
		if (!converter_enable_bit) begin
			track_o = 1'b0;
		end else if (start_source_select == scc_pkg::SRC_EXT_PIN && !delayed_track_select) begin
			track_o = !busy && !ext_level;
		end else begin
			track_o = (state != scc_pkg::ST_CONV);
		end
	end

	assign analog_enable_o     = converter_enable_bit;
	assign input_gain_select_o = converter_config_reg[scc_pkg::CFG_GAIN_BIT];
	assign sar_trial_o         = trial;

	// ************************************************************
	// Configuration register.
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge rst_b) begin
		if (!rst_b) begin
			converter_config_reg <= scc_pkg::CONFIG_RESET;
		end else if (wr_cfg) begin
			converter_config_reg <= sfr_wdata_i;
		end
	end

	// ************************************************************
	// Control register bits.
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge rst_b) begin
		if (!rst_b) begin
			converter_enable_bit <= scc_pkg::CONTROL_RESET[scc_pkg::CTL_EN_BIT];
			delayed_track_select <= scc_pkg::CONTROL_RESET[scc_pkg::CTL_TRACK_BIT];
			start_source_select  <= scc_pkg::CONTROL_RESET[scc_pkg::CTL_SRC_MSB:scc_pkg::CTL_SRC_LSB];
		end else if (wr_ctl) begin
			converter_enable_bit <= sfr_wdata_i[scc_pkg::CTL_EN_BIT];
			delayed_track_select <= sfr_wdata_i[scc_pkg::CTL_TRACK_BIT];
			start_source_select  <= sfr_wdata_i[scc_pkg::CTL_SRC_MSB:scc_pkg::CTL_SRC_LSB];
		end
	end

	// Completion wins over a software clear in the same cycle.
	always_ff @(posedge clk_sys_i or negedge rst_b) begin
		if (!rst_b) begin
			conversion_done_flag <= scc_pkg::CONTROL_RESET[scc_pkg::CTL_DONE_BIT];
		end else if (finish) begin
			conversion_done_flag <= 1'b1;
		end else if (wr_ctl) begin
			conversion_done_flag <= sfr_wdata_i[scc_pkg::CTL_DONE_BIT];
		end
	end

	assign conversion_done_flag_o = conversion_done_flag;

	// ************************************************************
	// Result bytes, formatted at completion.
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge rst_b) begin
		if (!rst_b) begin
			result_high_byte <= scc_pkg::RESULT_RESET;
			result_low_byte  <= scc_pkg::RESULT_RESET;
		end else if (finish) begin
			if (eight_bit_mode_sel) begin
				result_high_byte <= final_code[9:2];
				result_low_byte  <= 8'h00;
			end else if (left_justify_select) begin
				result_high_byte <= final_code[9:2];
				result_low_byte  <= {final_code[1:0], 6'h00};
			end else begin
				result_high_byte <= {6'h00, final_code[9:8]};
				result_low_byte  <= final_code[7:0];
			end
		end else begin
			if (sfr_wr_i && sfr_addr_i == scc_pkg::ADDR_RES_HI) begin
				result_high_byte <= sfr_wdata_i;
			end
			if (sfr_wr_i && sfr_addr_i == scc_pkg::ADDR_RES_LO) begin
				result_low_byte <= sfr_wdata_i;
			end
		end
	end

	// ************************************************************
	// Read data, registered; unmapped addresses return zero.
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge rst_b) begin
		if (!rst_b) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_rd_i) begin
			unique case (sfr_addr_i)
				scc_pkg::ADDR_CONFIG:  sfr_rdata_o <= converter_config_reg;
				scc_pkg::ADDR_RES_HI:  sfr_rdata_o <= result_high_byte;
				scc_pkg::ADDR_RES_LO:  sfr_rdata_o <= result_low_byte;
				scc_pkg::ADDR_CONTROL: sfr_rdata_o <= {converter_enable_bit,
				                                       delayed_track_select,
				                                       conversion_done_flag,
				                                       busy, 1'b0,
				                                       start_source_select};
				default:               sfr_rdata_o <= 8'h00;
			endcase
		end
	end

endmodule

`default_nettype wire

//--- tb/scc_conv_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Port-level checker for the conversion control block.
// ************************************************************
module scc_conv_ctrl_props (
	// Clock and reset.
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	// Register port.
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_wr_i,
	input  wire logic       sfr_rd_i,
	input  wire logic [7:0] sfr_rdata_o,
	// Converter outputs.
	input  wire logic [9:0] sar_trial_o,
	input  wire logic       analog_enable_o,
	input  wire logic       input_gain_select_o,
	input  wire logic       conversion_done_flag_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	// Control and configuration write decodes shared by the properties.
	wire logic ctl_wr = sfr_wr_i && sfr_addr_i == scc_pkg::ADDR_CONTROL;
	wire logic cfg_wr = sfr_wr_i && sfr_addr_i == scc_pkg::ADDR_CONFIG;

	// Enable and gain move only on a write, so no stray path can wake the converter.
	chk_enable_by_write: assert property ($changed(analog_enable_o) |-> $past(ctl_wr))
		else $error("enable changed without a control write");
	chk_gain_by_write: assert property ($changed(input_gain_select_o) |-> $past(cfg_wr))
		else $error("gain changed without a config write");
	// A shut-down converter leaves its trial code alone.
	chk_trial_frozen_off: assert property (!analog_enable_o [*3] |=> $stable(sar_trial_o))
		else $error("trial code moved while disabled");
	// The done flag is sticky and only software lowers it.
	chk_done_sticky: assert property (conversion_done_flag_o && !ctl_wr |=> conversion_done_flag_o)
		else $error("done flag cleared by hardware");
	chk_done_fall_cause: assert property ($fell(conversion_done_flag_o) |->
		$past(ctl_wr && !sfr_wdata_i[scc_pkg::CTL_DONE_BIT]))
		else $error("done flag fell without a clearing write");
	chk_done_rise_cause: assert property ($rose(conversion_done_flag_o) && !$past(ctl_wr) |->
		$past(analog_enable_o))
		else $error("done flag rose while disabled");
	chk_done_write_one: assert property (ctl_wr && sfr_wdata_i[scc_pkg::CTL_DONE_BIT] |=>
		conversion_done_flag_o)
		else $error("writing one did not set the done flag");
	// Read data is held between reads, so results cannot slip while software looks.
	chk_rdata_held: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
		else $error("read data changed without a read");

	cov_done_rise: cover property ($rose(conversion_done_flag_o));
	cov_result_read: cover property (sfr_rd_i && sfr_addr_i == scc_pkg::ADDR_RES_HI);
	cov_disable: cover property ($fell(analog_enable_o));
endmodule

bind scc_conv_ctrl scc_conv_ctrl_props scc_conv_ctrl_props_inst (
	.clk_sys_i, .rst_b_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o,
	.sar_trial_o, .analog_enable_o, .input_gain_select_o, .conversion_done_flag_o);

`default_nettype wire

//--- tb/scc_front_model.sv
`timescale 1ns/1ns
`default_nettype none

// Ideal comparator on a held level; no offset, so the final code equals the level.
module scc_front_model (
	// Held analog level as a code.
	input  wire logic [9:0] level_i,
	// Trial code and decision.
	input  wire logic [9:0] sar_trial_i,
	output logic            cmp_o
);
	// A trial at or below the level keeps its bit.
	assign cmp_o = sar_trial_i <= level_i;
endmodule

`default_nettype wire

//--- tb/sar_adc_conversion_control_bench.sv
`timescale 1ns/1ns
`default_nettype none

module sar_adc_conversion_control_bench;
	logic       clk_sys_i = 1'b0;
	logic       rst_b_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [6:0] trg = 7'h00;
	logic [1:0] split = 2'b00;
	logic [9:0] level = 10'h000;
	logic       cmp;
	logic [7:0] rdata;
	logic [9:0] trial;
	logic       done;
	logic       track;
	logic       en;
	logic       gain;
	int         n_errors = 0;
	int         n_checks = 0;
	int         gd[6] = '{7, 0, 1, 3, 4, 5};
	int         bd[6] = '{0, 3, 0, 0, 0, 0};

	scc_front_model scc_front_model_inst (.level_i(level), .sar_trial_i(trial), .cmp_o(cmp));
	scc_conv_ctrl scc_conv_ctrl_inst (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
		.t0_ovf_i(trg[0]), .t2_lo_ovf_i(trg[1]), .t2_hi_ovf_i(trg[2]), .t1_ovf_i(trg[3]),
		.external_convert_start_i(trg[4]), .t3_lo_ovf_i(trg[5]), .t3_hi_ovf_i(trg[6]),
		.t2_split8_i(split[0]), .t3_split8_i(split[1]), .cmp_i(cmp), .sar_trial_o(trial),
		.track_o(track), .analog_enable_o(en), .input_gain_select_o(gain),
		.conversion_done_flag_o(done));

	// ************************************************************
	// Clock, watchdog and shared tasks.
	// ************************************************************
	initial forever #4 clk_sys_i = ~clk_sys_i;

	// The longest run is a few thousand cycles; this leaves ample margin.
	initial begin
		#400000;
		n_errors++;
		test_done;
	end

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// The start pin is filtered by its synchroniser, so it is held for three clocks.
	task automatic pulse(input int k);
		@(posedge clk_sys_i);
		trg[k] <= 1'b1;
		repeat ((k == 4) ? 3 : 1) @(posedge clk_sys_i);
		trg[k] <= 1'b0;
	endtask

	// Counts edges until the done flag shows, bounded so a lost conversion cannot hang.
	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (done !== 1'b1 && n < 600);
	endtask

	// Reference formatting of a held level into the result pair.
	function automatic logic [15:0] fmt(input logic [9:0] v, input logic b8, input logic lj);
		if (b8) return {v[9:2], 8'h00};
		return lj ? {v, 6'h00} : {6'h00, v};
	endfunction

	task automatic chk_res(input logic b8, input logic lj);
		logic [7:0] hi;
		logic [7:0] lo;
		rd_reg(scc_pkg::ADDR_RES_HI, hi);
		rd_reg(scc_pkg::ADDR_RES_LO, lo);
		chk("result", fmt(level, b8, lj), {hi, lo});
	endtask

	// ************************************************************
	// Main sequence.
	// ************************************************************
	initial begin
		logic [7:0] v;
		logic [4:0] dv;
		logic [1:0] sp;
		logic       b8;
		logic       lj;
		logic       tm;
		logic       g;
		int         n;
		int         good;
		int         bad;
		void'($urandom(31583));
		repeat (8) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rd_reg(scc_pkg::ADDR_CONFIG, v);
		chk("config", {8'h00, scc_pkg::CONFIG_RESET}, {8'h00, v});
		chk("gain", 16'd1, {15'd0, gain});
		rd_reg(scc_pkg::ADDR_CONTROL, v);
		chk("control", {8'h00, scc_pkg::CONTROL_RESET}, {8'h00, v});
		chk("enable", 16'd0, {15'd0, en});
		chk("track off", 16'd0, {15'd0, track});
		// Software starts across widths, justification, tracking and divider values.
		for (int i = 0; i < 12; i++) begin
			dv = 5'($urandom_range(3));
			b8 = 1'($urandom);
			lj = 1'($urandom);
			tm = 1'($urandom);
			g  = 1'($urandom);
			@(posedge clk_sys_i);
			level <= 10'($urandom);
			wr_reg(scc_pkg::ADDR_CONFIG, {dv, lj, b8, g});
			#1 chk("gain", {15'd0, g}, {15'd0, gain});
			wr_reg(scc_pkg::ADDR_CONTROL, {1'b1, tm, 6'h00});
			#1 chk("done clear", 16'd0, {15'd0, done});
			chk("enable", 16'd1, {15'd0, en});
			chk("track idle", 16'd1, {15'd0, track});
			wr_reg(scc_pkg::ADDR_CONTROL, {1'b1, tm, 6'h10});
			wait_done(n);
			chk("cycles", 16'(((b8 ? 8 : 10) + (tm ? 3 : 0)) * (dv + 1)), 16'(n));
			rd_reg(scc_pkg::ADDR_CONTROL, v);
			chk("control", {8'h00, 1'b1, tm, 6'h20}, {8'h00, v});
			chk_res(b8, lj);
		end
		// Every start source; a wrong trigger first must be ignored.
		wr_reg(scc_pkg::ADDR_CONFIG, 8'h18);
		for (int s = 0; s < 6; s++) begin
			sp = 2'($urandom);
			good = (s == 2) ? (sp[0] ? 1 : 2) : (s == 5) ? (sp[1] ? 5 : 6) : gd[s];
			bad = (s == 2) ? 3 - good : (s == 5) ? 11 - good : bd[s];
			@(posedge clk_sys_i);
			level <= 10'($urandom);
			split <= sp;
			wr_reg(scc_pkg::ADDR_CONTROL, {5'b10000, 3'(s)});
			pulse(bad);
			repeat (60) @(posedge clk_sys_i);
			#1;
			chk("idle done", 16'd0, {15'd0, done});
			chk("track idle", 16'd1, {15'd0, track});
			if (s == 0) wr_reg(scc_pkg::ADDR_CONTROL, 8'h90);
			else pulse(good);
			repeat (6) @(posedge clk_sys_i);
			rd_reg(scc_pkg::ADDR_CONTROL, v);
			chk("busy", {8'h00, 5'b10010, 3'(s)}, {8'h00, v});
			chk("track conv", 16'd0, {15'd0, track});
			wait_done(n);
			chk("done", 16'd1, {15'd0, done});
			chk_res(1'b0, 1'b0);
		end
		// Abort by disabling, then a start while disabled must do nothing.
		wr_reg(scc_pkg::ADDR_CONFIG, 8'hf9);
		wr_reg(scc_pkg::ADDR_CONTROL, 8'h90);
		repeat (20) @(posedge clk_sys_i);
		wr_reg(scc_pkg::ADDR_CONTROL, 8'h00);
		#1 chk("enable", 16'd0, {15'd0, en});
		chk("track off", 16'd0, {15'd0, track});
		wr_reg(scc_pkg::ADDR_CONTROL, 8'h10);
		wait_done(n);
		chk("off done", 16'd0, {15'd0, done});
		chk_res(1'b0, 1'b0);
		test_done;
	end
endmodule

`default_nettype wire
